// ### rsc_pkg.sv
// Package: constants and types for the reset source controller
package rsc_pkg;

    // Register map (plain port, byte addresses)
    localparam logic [3:0] ADDR_THRESHOLD_SEL = 4'h0;
    localparam logic [3:0] ADDR_RESET_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_STATUS_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_MODE_CTRL = 4'h3;

    // Threshold codes
    localparam logic [7:0] THR_CODE_LOW = 8'h55;
    localparam logic [7:0] THR_CODE_MID1 = 8'h33;
    localparam logic [7:0] THR_CODE_MID2 = 8'h99;
    localparam logic [7:0] THR_CODE_HIGH = 8'haa;
    localparam logic [7:0] THR_POR_VALUE = THR_CODE_LOW;

    // Field positions in reset_source_flags
    localparam int FLAG_SUPPLY_DROP_BIT = 2;
    localparam int FLAG_BAD_CODE_BIT = 1;
    localparam int FLAG_WDOG_CODE_BIT = 0;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h87;
    localparam int MODE_FSYS_ON_BIT = 7;
    // Field positions in status register
    localparam int STAT_TIMEOUT_BIT = 1;
    localparam int STAT_PDOWN_BIT = 0;

    // Timing
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int SYS_CLK_NS = 20;
    localparam int DROP_QUALIFY_TIME_NS = 100;
    localparam int DROP_QUALIFY_CYCLES =
        (DROP_QUALIFY_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // Third synced rise falls 2 to 3 slow periods after the code goes bad
    localparam int BAD_CODE_SLOW_EDGES = 3;
    localparam int RESET_PULSE_CYCLES = 4;
    localparam logic [7:0] PORT_POR_VALUE = 8'hff;
    localparam logic [7:0] PC_RESET_VALUE = 8'h00;

    typedef enum logic [1:0]
    {
        RSC_MODE_NORMAL,
        RSC_MODE_SLOW,
        RSC_MODE_IDLE,
        RSC_MODE_SLEEP
    } rsc_mode_type;

    typedef struct packed
    {
        logic device_reset;
        logic core_restart;
        logic port_preset;
    } rsc_reset_out_type;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsc_bus_req_type;

    function automatic logic rsc_code_valid(input logic [7:0] code);
        return (code == THR_CODE_LOW) || (code == THR_CODE_MID1)
            || (code == THR_CODE_MID2) || (code == THR_CODE_HIGH);
    endfunction : rsc_code_valid

endpackage : rsc_pkg

// ### rsc_reset_source_controller.sv
// Module: reset source combiner with sticky reset-cause flags
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
//
// Function
// RULE1: After power-on, core restarts at address zero with registers preset.
// RULE2: Port data and direction registers power up all ones (inputs).
// RULE3: Supply-drop reset is always enabled; software cannot disable it.
// RULE4: Qualified low supply resets the device and sets supply-drop flag.
// RULE5: Low-supply pulses not exceeding qualify time are ignored.
// RULE6: Threshold select accepts only 0x55, 0x33, 0x99, 0xaa.
// RULE7: Invalid threshold code resets after 2-3 slow oscillator cycles.
// RULE8: Invalid-code reset sets the bad threshold code flag.
// RULE9: Invalid-code reset reloads threshold select with power-on value.
// RULE10: Genuine low-supply reset keeps threshold select contents.
// RULE11: Supply-drop reset is disabled during power-down mode.
// RULE12: Bad code flag survives resets; only software write clears it.
// RULE13: Watchdog time-out in run mode resets like supply drop, sets timeout.
// RULE14: Watchdog time-out in sleep/idle clears only PC and SP, sets flag.
// RULE15: Timeout/power-down flags: POR 0,0; drop unchanged; wdog 1,u or 1,1.
// RULE16: Supply-drop flag stays set until software writes zero.
// RULE17: Code check runs from slow oscillator; reset held until delay ends.
// RULE18: Unimplemented flag bits read zero and ignore writes.
module rsc_reset_source_controller
    import rsc_pkg::*;
(
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Sources
    input wire logic supply_low,
    input wire logic slow_internal_osc,
    input wire logic watchdog_timeout,
    input wire logic watchdog_code_bad,
    input wire rsc_mode_type cpu_mode,
    // Reset outputs
    output rsc_reset_out_type reset_out,
    output logic pc_sp_clear,
    output logic [7:0] port_data_preset,
    output logic [7:0] port_dir_preset,
    output logic [7:0] threshold_select,
    output logic watchdog_timeout_flag,
    output logic power_down_flag
);

    ////////////////////////////////////////////////////////////////////////
    logic power_down;
    logic [7:0] thr_reg;
    logic supply_drop_flag_reg;
    logic bad_threshold_code_flag_reg;
    logic wdog_code_flag_reg;
    logic fsys_on_reg;
    logic timeout_reg;
    logic pdown_reg;
    logic [7:0] drop_cnt_reg;
    logic drop_event;
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_prev_reg;
    logic osc_rise;
    logic [1:0] bad_cnt_reg;
    logic bad_event;
    logic wdog_run_event;
    logic wdog_halt_event;
    logic [2:0] pulse_cnt_reg;
    logic reset_active;
    logic rst_bus_wr;
    logic [7:0] rdata_next;

    assign power_down = (cpu_mode == RSC_MODE_IDLE)
        || (cpu_mode == RSC_MODE_SLEEP);
    assign rst_bus_wr = reg_wr && !reset_active;

    ////////////////////////////////////////////////////////////////////////
    // Supply-drop qualification; no software enable exists
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            drop_cnt_reg <= 8'h00;
        else if (!supply_low || power_down) // RULE11
            drop_cnt_reg <= 8'h00;
        else if (drop_cnt_reg <= 8'(DROP_QUALIFY_CYCLES))
            drop_cnt_reg <= drop_cnt_reg + 8'h01; // RULE5
    end

    // Fires once, when the low level has outlasted the qualify time
    assign drop_event = (drop_cnt_reg == 8'(DROP_QUALIFY_CYCLES)); // RULE3

    ////////////////////////////////////////////////////////////////////////
    // Slow oscillator is sampled; the second stage and its delayed copy (third stage) feed edge logic
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_s1_reg <= slow_internal_osc;
            osc_s2_reg <= osc_s1_reg;
            osc_prev_reg <= osc_s2_reg;
        end
    end

    assign osc_rise = osc_s2_reg && !osc_prev_reg;

    // Count slow edges while the code stays invalid
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            bad_cnt_reg <= 2'h0;
        else if (rsc_code_valid(thr_reg)) // RULE6
            bad_cnt_reg <= 2'h0;
        else if (osc_rise && bad_cnt_reg < 2'(BAD_CODE_SLOW_EDGES))
            bad_cnt_reg <= bad_cnt_reg + 2'h1; // RULE17
    end

    assign bad_event = osc_rise
        && (bad_cnt_reg == 2'(BAD_CODE_SLOW_EDGES - 1)); // RULE7

    assign wdog_run_event = watchdog_timeout && !power_down;
    assign wdog_halt_event = watchdog_timeout && power_down;

    ////////////////////////////////////////////////////////////////////////
    // Reset pulse generation
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pulse_cnt_reg <= 3'(RESET_PULSE_CYCLES);
        else if (drop_event || bad_event || wdog_run_event // RULE13
                 || watchdog_code_bad)
            pulse_cnt_reg <= 3'(RESET_PULSE_CYCLES); // RULE4
        else if (pulse_cnt_reg != 3'h0)
            pulse_cnt_reg <= pulse_cnt_reg - 3'h1;
    end

    assign reset_active = (pulse_cnt_reg != 3'h0);

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reset_out <= '{device_reset: 1'b1, core_restart: 1'b1,
                           port_preset: 1'b1}; // RULE1
            pc_sp_clear <= 1'b1;
            port_data_preset <= PORT_POR_VALUE; // RULE2
            port_dir_preset <= PORT_POR_VALUE; // RULE2
        end
        else
        begin
            reset_out.device_reset <= reset_active;
            reset_out.core_restart <= reset_active;
            reset_out.port_preset <= reset_active;
            pc_sp_clear <= reset_active || wdog_halt_event; // RULE14
            port_data_preset <= PORT_POR_VALUE;
            port_dir_preset <= PORT_POR_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold select register
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            thr_reg <= THR_POR_VALUE;
        else if (bad_event)
            thr_reg <= THR_POR_VALUE; // RULE9
        else if (rst_bus_wr && reg_addr == ADDR_THRESHOLD_SEL)
            thr_reg <= reg_wdata; // RULE10
    end

    assign threshold_select = thr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sticky cause flags: hardware set wins over a software clear
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            supply_drop_flag_reg <= 1'b0;
            bad_threshold_code_flag_reg <= 1'b0;
            wdog_code_flag_reg <= 1'b0;
            fsys_on_reg <= 1'b0;
        end
        else
        begin
            if (drop_event)
                supply_drop_flag_reg <= 1'b1; // RULE4
            else if (reg_wr && reg_addr == ADDR_RESET_FLAGS)
                supply_drop_flag_reg <=
                    reg_wdata[FLAG_SUPPLY_DROP_BIT]; // RULE16
            if (bad_event)
                bad_threshold_code_flag_reg <= 1'b1; // RULE8
            else if (reg_wr && reg_addr == ADDR_RESET_FLAGS)
                bad_threshold_code_flag_reg <=
                    reg_wdata[FLAG_BAD_CODE_BIT]; // RULE12
            if (watchdog_code_bad)
                wdog_code_flag_reg <= 1'b1;
            else if (reg_wr && reg_addr == ADDR_RESET_FLAGS)
                wdog_code_flag_reg <= reg_wdata[FLAG_WDOG_CODE_BIT];
            if (reg_wr && reg_addr == ADDR_RESET_FLAGS)
                fsys_on_reg <= reg_wdata[MODE_FSYS_ON_BIT];
        end
    end

    // Timeout and power-down status flags
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timeout_reg <= 1'b0; // RULE15
            pdown_reg <= 1'b0;
        end
        else if (watchdog_timeout)
        begin
            timeout_reg <= 1'b1; // RULE13
            if (power_down)
                pdown_reg <= 1'b1; // RULE15
        end
        else if (reg_wr && reg_addr == ADDR_STATUS_FLAGS)
        begin
            timeout_reg <= reg_wdata[STAT_TIMEOUT_BIT];
            pdown_reg <= reg_wdata[STAT_PDOWN_BIT];
        end
    end

    assign watchdog_timeout_flag = timeout_reg;
    assign power_down_flag = pdown_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            ADDR_THRESHOLD_SEL: rdata_next = thr_reg;
            ADDR_RESET_FLAGS:
            begin
                rdata_next[MODE_FSYS_ON_BIT] = fsys_on_reg;
                rdata_next[FLAG_SUPPLY_DROP_BIT] = supply_drop_flag_reg;
                rdata_next[FLAG_BAD_CODE_BIT] = bad_threshold_code_flag_reg;
                rdata_next[FLAG_WDOG_CODE_BIT] = wdog_code_flag_reg;
                rdata_next = rdata_next & FLAG_IMPL_MASK; // RULE18
            end
            ADDR_STATUS_FLAGS:
            begin
                rdata_next[STAT_TIMEOUT_BIT] = timeout_reg;
                rdata_next[STAT_PDOWN_BIT] = pdown_reg;
            end
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_DROP_SETS_FLAG: assert property ( // RULE4
        @(posedge sys_clk) disable iff (sys_rst)
        drop_event |=> supply_drop_flag_reg && reset_active)
        else $error("Qualified drop did not set flag and reset");

    AST_SHORT_DIP_IGNORED: assert property ( // RULE5
        @(posedge sys_clk) disable iff (sys_rst)
        !supply_low |=> !drop_event)
        else $error("Drop event without sustained low supply");

    AST_NO_DROP_IN_PDOWN: assert property ( // RULE11
        @(posedge sys_clk) disable iff (sys_rst)
        power_down |=> drop_cnt_reg == 8'h00)
        else $error("Drop qualifier ran in power-down");

    AST_BAD_CODE_RELOAD: assert property ( // RULE9
        @(posedge sys_clk) disable iff (sys_rst)
        bad_event |=> thr_reg == THR_POR_VALUE
            && bad_threshold_code_flag_reg && reset_active)
        else $error("Invalid code reset did not reload and flag");

    AST_BAD_CODE_DELAY: assert property ( // RULE17
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(rsc_code_valid(thr_reg)) |-> bad_cnt_reg == 2'h0 && !bad_event)
        else $error("Invalid-code delay did not start from zero");

    AST_FLAG_STICKY: assert property ( // RULE12
        @(posedge sys_clk) disable iff (sys_rst)
        bad_threshold_code_flag_reg
            && !(reg_wr && reg_addr == ADDR_RESET_FLAGS)
            |=> bad_threshold_code_flag_reg)
        else $error("Bad code flag cleared without write");

    AST_DROP_FLAG_STICKY: assert property ( // RULE16
        @(posedge sys_clk) disable iff (sys_rst)
        supply_drop_flag_reg && !(reg_wr && reg_addr == ADDR_RESET_FLAGS)
            |=> supply_drop_flag_reg)
        else $error("Drop flag cleared without write");

    AST_WDOG_RUN_RESET: assert property ( // RULE13
        @(posedge sys_clk) disable iff (sys_rst)
        wdog_run_event |=> timeout_reg && reset_active
            ##1 reset_out.device_reset)
        else $error("Run-mode time-out did not reset");

    AST_WDOG_HALT: assert property ( // RULE14
        @(posedge sys_clk) disable iff (sys_rst)
        wdog_halt_event |=> pc_sp_clear && timeout_reg && pdown_reg)
        else $error("Halt time-out did not clear PC and SP");

    AST_HALT_NO_RESET: assert property ( // RULE14
        @(posedge sys_clk) disable iff (sys_rst)
        wdog_halt_event && !reset_active && !drop_event && !bad_event
            && !watchdog_code_bad |=> !reset_active)
        else $error("Halt time-out raised a device reset");

    AST_WDOG_RUN_PDF: assert property ( // RULE15
        @(posedge sys_clk) disable iff (sys_rst)
        wdog_run_event |=> pdown_reg == $past(pdown_reg))
        else $error("Run-mode time-out changed power-down flag");

    AST_THR_KEPT_ON_DROP: assert property ( // RULE10
        @(posedge sys_clk) disable iff (sys_rst)
        drop_event && !rst_bus_wr && !bad_event
            |=> thr_reg == $past(thr_reg))
        else $error("Supply-drop reset changed threshold select");

    COV_DROP: cover property (@(posedge sys_clk) drop_event);
    COV_BAD_CODE: cover property (@(posedge sys_clk) bad_event);
    COV_WDOG_RUN: cover property (@(posedge sys_clk) wdog_run_event);
    COV_WDOG_HALT: cover property (@(posedge sys_clk) wdog_halt_event);
    COV_WDOG_IDLE: cover property (@(posedge sys_clk)
        wdog_halt_event && cpu_mode == RSC_MODE_IDLE);

endmodule : rsc_reset_source_controller

// ### rsc_far_side_model.sv
// Far-side model: supply comparator, slow oscillator, watchdog and core mode
`timescale 1ns/100ps
module rsc_far_side_model
    import rsc_pkg::*;
#(
    parameter int SLOW_HALF = 16
)
(
    // Clock
    input wire logic sys_clk,
    // Source outputs
    output logic supply_low,
    output logic slow_internal_osc,
    output logic watchdog_timeout,
    output logic watchdog_code_bad,
    output rsc_mode_type cpu_mode
);
    int osc_cnt;

    initial
    begin
        supply_low = 1'b0;
        slow_internal_osc = 1'b0;
        watchdog_timeout = 1'b0;
        watchdog_code_bad = 1'b0;
        cpu_mode = RSC_MODE_NORMAL;
        osc_cnt = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator runs free, unrelated to any frame
    always @(posedge sys_clk)
    begin
        if (osc_cnt == SLOW_HALF - 1)
        begin
            osc_cnt <= 0;
            slow_internal_osc <= ~slow_internal_osc;
        end
        else
            osc_cnt <= osc_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic drop(input int n);
        @(posedge sys_clk);
        supply_low <= 1'b1;
        repeat (n) @(posedge sys_clk);
        supply_low <= 1'b0;
    endtask : drop

    task automatic wdog(input logic bad_code);
        @(posedge sys_clk);
        watchdog_timeout <= ~bad_code;
        watchdog_code_bad <= bad_code;
        @(posedge sys_clk);
        watchdog_timeout <= 1'b0;
        watchdog_code_bad <= 1'b0;
    endtask : wdog

    task automatic set_mode(input rsc_mode_type m);
        @(posedge sys_clk);
        cpu_mode <= m;
    endtask : set_mode
endmodule : rsc_far_side_model

// ### tb_rsc_reset_source_controller.sv
// Testbench for the reset source controller
`timescale 1ns/100ps
module tb_rsc_reset_source_controller;
    import rsc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata, thr_sel, pd_pre, pdir_pre;
    logic supply_low, slow_osc, wd_to, wd_bad, pc_sp_clear, to_flag, pd_flag;
    rsc_mode_type cpu_mode;
    rsc_reset_out_type reset_out;
    int n_fail = 0;
    int num_checks = 0;
    int n;
    logic [7:0] thr_list [4] = '{8'h33, 8'h99, 8'haa, 8'h55};

    always #10 sys_clk = ~sys_clk;

    rsc_far_side_model rsc_far_side_model_i (.sys_clk(sys_clk),
        .supply_low(supply_low), .slow_internal_osc(slow_osc),
        .watchdog_timeout(wd_to), .watchdog_code_bad(wd_bad),
        .cpu_mode(cpu_mode));

    rsc_reset_source_controller rsc_reset_source_controller_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .supply_low(supply_low),
        .slow_internal_osc(slow_osc), .watchdog_timeout(wd_to),
        .watchdog_code_bad(wd_bad), .cpu_mode(cpu_mode),
        .reset_out(reset_out), .pc_sp_clear(pc_sp_clear),
        .port_data_preset(pd_pre), .port_dir_preset(pdir_pre),
        .threshold_select(thr_sel), .watchdog_timeout_flag(to_flag),
        .power_down_flag(pd_flag));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd_chk

    // Bounded wait for reset level lev; n counts the cycles waited
    task automatic wait_lev(input logic lev, output int n);
        n = 0;
        while (reset_out.device_reset !== lev)
        begin
            if (n >= 300)
            begin
                n_fail++;
                $display("mismatch at %0t: reset wait timed out", $time);
                end_of_test();
            end
            @(posedge sys_clk);
            #1 n++;
        end
    endtask : wait_lev

    task automatic pulse_seen(output int n);
        int m;
        wait_lev(1'b1, n);
        check(8'(reset_out), 8'h07);
        wait_lev(1'b0, m);
    endtask : pulse_seen

    // Counts reset and core-clear cycles over a window
    task automatic watch(input int len, output int r, output int c);
        r = 0;
        c = 0;
        repeat (len)
        begin
            @(posedge sys_clk);
            #1 r += int'(reset_out.device_reset);
            c += int'(pc_sp_clear);
        end
    endtask : watch

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int r;
        int c;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge sys_clk);
        check(reset_out.device_reset, 1'b1);
        check(8'(reset_out), 8'h07);
        check(pc_sp_clear, 1'b1);
        check(pd_pre, 8'hff);
        check(pdir_pre, 8'hff);
        sys_rst <= 1'b0;
        wait_lev(1'b0, n);
        check(8'(reset_out), 8'h00);
        rd_chk(ADDR_THRESHOLD_SEL, 8'h55);
        rd_chk(ADDR_RESET_FLAGS, 8'h00);
        rd_chk(ADDR_STATUS_FLAGS, 8'h00);
        wr(ADDR_RESET_FLAGS, 8'h78);
        rd_chk(ADDR_RESET_FLAGS, 8'h00);
        wr(4'hf, 8'h12);
        rd_chk(4'hf, 8'h00);
        foreach (thr_list[i])
        begin
            wr(ADDR_THRESHOLD_SEL, thr_list[i]);
            rd_chk(ADDR_THRESHOLD_SEL, thr_list[i]);
            check(thr_sel, thr_list[i]);
        end
        watch(120, r, c);
        check(8'(r), 8'h00);
        rsc_far_side_model_i.drop(3);
        watch(20, r, c);
        check(8'(r), 8'h00);
        wr(ADDR_THRESHOLD_SEL, 8'haa);
        rsc_far_side_model_i.drop(8);
        pulse_seen(n);
        rd_chk(ADDR_RESET_FLAGS, 8'h04);
        rd_chk(ADDR_THRESHOLD_SEL, 8'haa);
        rd_chk(ADDR_STATUS_FLAGS, 8'h00);
        wr(ADDR_THRESHOLD_SEL, 8'h12);
        pulse_seen(n);
        check(8'(n >= 64 && n <= 100), 8'h01);
        rd_chk(ADDR_THRESHOLD_SEL, 8'h55);
        rd_chk(ADDR_RESET_FLAGS, 8'h06);
        rsc_far_side_model_i.wdog(1'b1);
        pulse_seen(n);
        rd_chk(ADDR_RESET_FLAGS, 8'h07);
        wr(ADDR_RESET_FLAGS, 8'h00);
        rd_chk(ADDR_RESET_FLAGS, 8'h00);
        rsc_far_side_model_i.wdog(1'b0);
        pulse_seen(n);
        rd_chk(ADDR_STATUS_FLAGS, 8'h02);
        check(to_flag, 1'b1);
        wr(ADDR_STATUS_FLAGS, 8'h00);
        rsc_far_side_model_i.set_mode(RSC_MODE_SLEEP);
        rsc_far_side_model_i.drop(12);
        watch(20, r, c);
        check(8'(r), 8'h00);
        rd_chk(ADDR_RESET_FLAGS, 8'h00);
        fork
            rsc_far_side_model_i.wdog(1'b0);
            watch(12, r, c);
        join
        check(8'(r), 8'h00);
        check(8'(c), 8'h01);
        check(to_flag, 1'b1);
        check(pd_flag, 1'b1);
        wr(ADDR_STATUS_FLAGS, 8'h00);
        rsc_far_side_model_i.set_mode(RSC_MODE_IDLE);
        fork
            rsc_far_side_model_i.wdog(1'b0);
            watch(12, r, c);
        join
        check(8'(r), 8'h00);
        check(8'(c), 8'h01);
        rd_chk(ADDR_STATUS_FLAGS, 8'h03);
        rsc_far_side_model_i.set_mode(RSC_MODE_SLOW);
        rsc_far_side_model_i.wdog(1'b0);
        pulse_seen(n);
        rd_chk(ADDR_STATUS_FLAGS, 8'h03);
        rsc_far_side_model_i.drop(8);
        pulse_seen(n);
        rd_chk(ADDR_STATUS_FLAGS, 8'h03);
        rd_chk(ADDR_RESET_FLAGS, 8'h04);
        end_of_test();
    end
endmodule : tb_rsc_reset_source_controller
